// ---- hw/oled_i2c_pkg.sv ----
// Constants, states and carriers of the two-wire display write port.
// Assumes a system clock far faster than the serial clock of the link.
package oled_i2c_pkg;

	// Address byte layout
	localparam logic [5:0] ADDR_FIXED    = 6'h1E;
	localparam int         ADDR_RW_BIT   = 0;

	// Control byte layout
	localparam int         CTRL_CONT_BIT = 7;
	localparam int         CTRL_DC_BIT   = 6;
	localparam logic [5:0] CTRL_LOW_ZERO = 6'h00;

	// Column commands, upper nibble
	localparam logic [3:0] CMD_COL_LO    = 4'h0;
	localparam logic [3:0] CMD_COL_HI    = 4'h1;

	// Bit counting within a byte and its acknowledge slot
	localparam logic [3:0] BIT_CNT_RST   = 4'h0;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT      = 4'h8;

	// Values after reset
	localparam logic [7:0] COLUMN_RST    = 8'h00;
	localparam logic [7:0] BYTE_RST      = 8'h00;

	typedef enum logic [5:0]
	{
		ST_IDLE   = 6'h01,
		ST_ADDR   = 6'h02,
		ST_CTRL   = 6'h04,
		ST_ONE    = 6'h08,
		ST_STREAM = 6'h10,
		ST_IGNORE = 6'h20
	} parse_state_t;

	typedef struct packed
	{
		logic [7:0] column;
		logic [7:0] data;
	} mem_write_t;

endpackage

// ---- hw/bit_sync.sv ----
// Two flip-flop level synchroniser, one chain per bit.
// Assumes each input bit is a level that changes slowly against i_clk.
module bit_sync
#(
	parameter int         WIDTH     = 1,
	parameter logic [0:0] RESET_VAL = 1'b0
)
(
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;

	always_comb
	begin
		meta_next = i_async;
		sync_next = meta_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			meta_reg <= {WIDTH{RESET_VAL}};
			o_sync   <= {WIDTH{RESET_VAL}};
		end
		else
		begin
			meta_reg <= meta_next;
			o_sync   <= sync_next;
		end
	end

endmodule // bit_sync

// ---- hw/oled_i2c_write_port.sv ----
// Write-only two-wire slave of the sub-display controller.
// Assumes the serial clock pin also clocks the link-side capture logic
// and that SDA is pulled up outside; the port only ever pulls it low.

module oled_i2c_write_port
(
	// System clock and reset
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_rst_n,
	// Link pins
	input  wire logic                    i_link_scl,
	input  wire logic                    i_sda_in,
	output logic                         o_sda_out,
	output logic                         o_sda_oe,
	input  wire logic                    i_address_select_strap,
	// Display memory writes
	output logic                         o_mem_wr,
	output oled_i2c_pkg::mem_write_t     o_mem,
	// Commands
	output logic                         o_cmd_valid,
	output logic [7:0]                   o_cmd_byte,
	// Status
	output logic [7:0]                   o_column,
	output logic                         o_addressed
);

	// Link domain: one bit per serial clock rise, read only once settled
	logic link_bit_reg;
	logic link_bit_next;

	always_comb
	begin
		link_bit_next = i_sda_in;
	end

	always_ff @(posedge i_link_scl)
	begin
		link_bit_reg <= link_bit_next;
	end

	// System domain: pins pass two flip-flops
	logic [2:0] sync_in;
	logic [2:0] sync_out;
	logic       scl_s;
	logic       sda_s;
	logic       strap_s;

	assign sync_in = {i_address_select_strap, i_sda_in, i_link_scl};

	bit_sync #(.WIDTH(3), .RESET_VAL(1'b1)) u_pin_sync
	(
		.i_clk   (i_sys_clk),
		.i_rst_n (i_rst_n),
		.i_async (sync_in),
		.o_sync  (sync_out)
	);

	assign scl_s   = sync_out[0];
	assign sda_s   = sync_out[1];
	assign strap_s = sync_out[2];

	// Parser state
	oled_i2c_pkg::parse_state_t state_reg;
	oled_i2c_pkg::parse_state_t state_next;
	logic       scl_d_reg;
	logic       scl_d_next;
	logic       sda_d_reg;
	logic       sda_d_next;
	logic [3:0] bit_cnt_reg;
	logic [3:0] bit_cnt_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic       ack_en_reg;
	logic       ack_en_next;
	logic       sda_oe_next;
	logic       dc_reg;
	logic       dc_next;
	logic [7:0] column_next;
	logic       mem_wr_next;
	oled_i2c_pkg::mem_write_t mem_next;
	logic       cmd_valid_next;
	logic [7:0] cmd_byte_next;
	logic       addressed_next;

	logic       start_evt;
	logic       stop_evt;
	logic       fall_evt;
	logic       bit_evt;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       addr_hit;

	assign start_evt = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_evt  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign fall_evt  = scl_d_reg & ~scl_s;
	// Link bit stands from the serial clock rise, two flip-flops ahead of its synced rise
	assign bit_evt   = scl_s & ~scl_d_reg;
	assign rx_byte   = {shift_reg[6:0], link_bit_reg};
	assign byte_done = bit_evt && (state_reg != oled_i2c_pkg::ST_IDLE)
		&& (bit_cnt_reg == oled_i2c_pkg::LAST_DATA_BIT);
	assign addr_hit  = (rx_byte[7:1] ==
		{oled_i2c_pkg::ADDR_FIXED, strap_s});

	always_comb
	begin
		logic exec;
		logic exec_data;
		exec           = 1'b0;
		exec_data      = 1'b0;
		state_next     = state_reg;
		scl_d_next     = scl_s;
		sda_d_next     = sda_s;
		bit_cnt_next   = bit_cnt_reg;
		shift_next     = shift_reg;
		ack_en_next    = ack_en_reg;
		sda_oe_next    = o_sda_oe;
		dc_next        = dc_reg;
		column_next    = o_column;
		mem_wr_next    = 1'b0;
		mem_next       = o_mem;
		cmd_valid_next = 1'b0;
		cmd_byte_next  = o_cmd_byte;
		if (start_evt)
		begin
			state_next   = oled_i2c_pkg::ST_ADDR;
			bit_cnt_next = oled_i2c_pkg::BIT_CNT_RST;
			ack_en_next  = 1'b0;
			sda_oe_next  = 1'b0;
		end
		else if (stop_evt)
		begin
			state_next   = oled_i2c_pkg::ST_IDLE;
			bit_cnt_next = oled_i2c_pkg::BIT_CNT_RST;
			ack_en_next  = 1'b0;
			sda_oe_next  = 1'b0;
		end
		else
		begin
			if (fall_evt)
			begin
				// Pull low across the whole ninth clock
				if (bit_cnt_reg == oled_i2c_pkg::ACK_SLOT && ack_en_reg)
					sda_oe_next = 1'b1;
				else if (bit_cnt_reg == oled_i2c_pkg::BIT_CNT_RST)
					sda_oe_next = 1'b0;
			end
			if (bit_evt && state_reg != oled_i2c_pkg::ST_IDLE)
			begin
				if (bit_cnt_reg == oled_i2c_pkg::ACK_SLOT)
				begin
					bit_cnt_next = oled_i2c_pkg::BIT_CNT_RST;
					ack_en_next  = 1'b0;
				end
				else
				begin
					shift_next   = rx_byte;
					bit_cnt_next = bit_cnt_reg + 4'h1;
				end
			end
			if (byte_done)
			begin
				unique case (state_reg)
					oled_i2c_pkg::ST_IDLE:
						state_next = oled_i2c_pkg::ST_IDLE;
					oled_i2c_pkg::ST_ADDR:
					begin
						if (addr_hit)
						begin
							ack_en_next = 1'b1;
							// Read mode is acknowledged then sat out
							if (rx_byte[oled_i2c_pkg::ADDR_RW_BIT])
								state_next = oled_i2c_pkg::ST_IGNORE;
							else
								state_next = oled_i2c_pkg::ST_CTRL;
						end
						else
							state_next = oled_i2c_pkg::ST_IGNORE;
					end
					oled_i2c_pkg::ST_CTRL:
					begin
						ack_en_next = 1'b1;
						if (rx_byte[5:0] == oled_i2c_pkg::CTRL_LOW_ZERO)
						begin
							dc_next = rx_byte[oled_i2c_pkg::CTRL_DC_BIT];
							if (rx_byte[oled_i2c_pkg::CTRL_CONT_BIT])
								state_next = oled_i2c_pkg::ST_ONE;
							else
								state_next = oled_i2c_pkg::ST_STREAM;
						end
						else
						begin
							// Not a control byte: display data stream
							exec       = 1'b1;
							exec_data  = 1'b1;
							dc_next    = 1'b1;
							state_next = oled_i2c_pkg::ST_STREAM;
						end
					end
					oled_i2c_pkg::ST_ONE:
					begin
						ack_en_next = 1'b1;
						exec        = 1'b1;
						exec_data   = dc_reg;
						state_next  = oled_i2c_pkg::ST_CTRL;
					end
					oled_i2c_pkg::ST_STREAM:
					begin
						ack_en_next = 1'b1;
						exec        = 1'b1;
						exec_data   = dc_reg;
					end
					oled_i2c_pkg::ST_IGNORE:
						state_next = oled_i2c_pkg::ST_IGNORE;
				endcase
			end
			if (exec && exec_data)
			begin
				mem_wr_next     = 1'b1;
				mem_next.column = o_column;
				mem_next.data   = rx_byte;
				column_next     = o_column + 8'h01;
			end
			else if (exec)
			begin
				cmd_valid_next = 1'b1;
				cmd_byte_next  = rx_byte;
				if (rx_byte[7:4] == oled_i2c_pkg::CMD_COL_LO)
					column_next[3:0] = rx_byte[3:0];
				else if (rx_byte[7:4] == oled_i2c_pkg::CMD_COL_HI)
					column_next[7:4] = rx_byte[3:0];
			end
		end
		addressed_next = state_next inside {oled_i2c_pkg::ST_CTRL,
			oled_i2c_pkg::ST_ONE, oled_i2c_pkg::ST_STREAM};
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			state_reg    <= oled_i2c_pkg::ST_IDLE;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
			bit_cnt_reg  <= oled_i2c_pkg::BIT_CNT_RST;
			shift_reg    <= oled_i2c_pkg::BYTE_RST;
			ack_en_reg   <= 1'b0;
			o_sda_oe     <= 1'b0;
			dc_reg       <= 1'b0;
			o_column     <= oled_i2c_pkg::COLUMN_RST;
			o_mem_wr     <= 1'b0;
			o_mem        <= '0;
			o_cmd_valid  <= 1'b0;
			o_cmd_byte   <= oled_i2c_pkg::BYTE_RST;
			o_addressed  <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			scl_d_reg    <= scl_d_next;
			sda_d_reg    <= sda_d_next;
			bit_cnt_reg  <= bit_cnt_next;
			shift_reg    <= shift_next;
			ack_en_reg   <= ack_en_next;
			o_sda_oe     <= sda_oe_next;
			dc_reg       <= dc_next;
			o_column     <= column_next;
			o_mem_wr     <= mem_wr_next;
			o_mem        <= mem_next;
			o_cmd_valid  <= cmd_valid_next;
			o_cmd_byte   <= cmd_byte_next;
			o_addressed  <= addressed_next;
		end
	end

	// Open drain: only ever pulls low
	assign o_sda_out = 1'b0;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	start_resets_parser_a: assert property (
		start_evt |=> state_reg == oled_i2c_pkg::ST_ADDR
			&& bit_cnt_reg == oled_i2c_pkg::BIT_CNT_RST && !o_sda_oe)
		else $error("start did not reset the parser");
	stop_goes_idle_a: assert property (
		stop_evt |=> state_reg == oled_i2c_pkg::ST_IDLE && !o_sda_oe)
		else $error("stop did not end the transfer");
	address_mismatch_a: assert property (
		byte_done && !start_evt && !stop_evt
			&& state_reg == oled_i2c_pkg::ST_ADDR && !addr_hit
			|=> state_reg == oled_i2c_pkg::ST_IGNORE && !ack_en_reg)
		else $error("foreign address was taken");
	ack_drive_a: assert property (
		fall_evt && !start_evt && !stop_evt && ack_en_reg
			&& bit_cnt_reg == oled_i2c_pkg::ACK_SLOT |=> o_sda_oe)
		else $error("acknowledge not driven");
	ack_hold_a: assert property (
		$fell(o_sda_oe) |-> $past(start_evt || stop_evt || (fall_evt
			&& bit_cnt_reg == oled_i2c_pkg::BIT_CNT_RST)))
		else $error("acknowledge dropped early");
	column_increment_a: assert property (
		mem_wr_next |=> o_column == $past(o_column) + 8'h01
			&& o_mem.column == $past(o_column))
		else $error("column pointer not advanced");
	stream_mode_a: assert property (
		byte_done && !start_evt && !stop_evt
			&& state_reg == oled_i2c_pkg::ST_CTRL
			&& rx_byte[5:0] == oled_i2c_pkg::CTRL_LOW_ZERO
			&& !rx_byte[oled_i2c_pkg::CTRL_CONT_BIT]
			|=> state_reg == oled_i2c_pkg::ST_STREAM)
		else $error("continuation zero did not stream");
	column_low_nibble_a: assert property (
		cmd_valid_next && rx_byte[7:4] == oled_i2c_pkg::CMD_COL_LO
			|=> o_cmd_valid && o_column[3:0] == $past(rx_byte[3:0]))
		else $error("low column nibble not loaded");
	ignore_quiet_a: assert property (
		state_reg == oled_i2c_pkg::ST_IGNORE && !ack_en_reg
			&& bit_cnt_reg != oled_i2c_pkg::BIT_CNT_RST
			|-> !o_sda_oe && !o_mem_wr && !o_cmd_valid)
		else $error("ignored transfer disturbed the bus");

endmodule // oled_i2c_write_port

// ---- sim/i2c_master_model.sv ----
// Behavioural two-wire bus master that writes into the display port.
// Assumes a pull-up on SDA; the bench resolves the wire level.
module i2c_master_model
(
	// Clocks
	input  wire logic i_sys_clk,
	input  wire logic i_link_clk,
	// Bus
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_low
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		o_scl     = 1'b1;
		o_sda_low = 1'b0;
	end

	// One phase of the serial clock
	task automatic phase();
		repeat (17) @(posedge i_link_clk);
		@(negedge i_sys_clk);
	endtask

	// Clock low, data held a little past the edge
	task automatic fall();
		o_scl = 1'b0;
		repeat (2) @(negedge i_sys_clk);
	endtask

	// Also a repeated start when called mid-transfer
	task automatic start();
		o_sda_low = 1'b0;
		phase();
		o_scl = 1'b1;
		phase();
		o_sda_low = 1'b1;
		phase();
		fall();
	endtask

	task automatic stop();
		o_sda_low = 1'b1;
		phase();
		o_scl = 1'b1;
		phase();
		o_sda_low = 1'b0;
		phase();
	endtask

	// MSB first, one bit per clock, then the acknowledge slot
	task automatic put(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			o_sda_low = ~b[i];
			phase();
			o_scl = 1'b1;
			phase();
			fall();
		end
		o_sda_low = 1'b0;
		phase();
		o_scl = 1'b1;
		ack = ~i_sda;
		phase();
		// SDA out tied to SDA in here, so the level is trusted
		ack = ack & ~i_sda;
		fall();
	endtask
endmodule // i2c_master_model

// ---- sim/oled_i2c_write_port_tb_top.sv ----
// Self-checking bench of the two-wire display write port.
// Assumes the master model as far side and a pulled-up SDA wire.
module oled_i2c_write_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic                     sys_clk;
	logic                     link_clk;
	logic                     rst_n;
	logic                     strap;
	logic                     scl;
	logic                     sda_low;
	logic                     sda_wire;
	logic                     sda_out;
	logic                     sda_oe;
	logic                     mem_wr;
	oled_i2c_pkg::mem_write_t mem;
	logic                     cmd_valid;
	logic [7:0]               cmd_byte;
	logic [7:0]               column;
	logic                     addressed;
	logic [15:0]              mem_q[$];
	logic [7:0]               cmd_q[$];
	int                       n_errors = 0;
	int                       n_checks = 0;

	assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end

	oled_i2c_write_port uut
	(
		.i_sys_clk              (sys_clk),
		.i_rst_n                (rst_n),
		.i_link_scl             (scl),
		.i_sda_in               (sda_wire),
		.o_sda_out              (sda_out),
		.o_sda_oe               (sda_oe),
		.i_address_select_strap (strap),
		.o_mem_wr               (mem_wr),
		.o_mem                  (mem),
		.o_cmd_valid            (cmd_valid),
		.o_cmd_byte             (cmd_byte),
		.o_column               (column),
		.o_addressed            (addressed)
	);

	i2c_master_model m
	(
		.i_sys_clk  (sys_clk),
		.i_link_clk (link_clk),
		.i_sda      (sda_wire),
		.o_scl      (scl),
		.o_sda_low  (sda_low)
	);

	// Records every write and command pulse
	always @(negedge sys_clk)
	begin
		if (mem_wr === 1'b1)
			mem_q.push_back(mem);
		if (cmd_valid === 1'b1)
			cmd_q.push_back(cmd_byte);
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	task automatic xfer(input logic [7:0] b, input logic exp_ack);
		logic ack;
		m.put(b, ack);
		check(16'(ack), 16'(exp_ack));
	endtask

	task automatic clear();
		mem_q.delete();
		cmd_q.delete();
	endtask

	task automatic sc_reset();
		check(16'(mem), 16'h0000);
		check(16'({sda_oe, mem_wr, cmd_valid, addressed, column}),
			16'h0000);
	endtask

	task automatic sc_addr();
		logic hit;
		clear();
		for (int s = 0; s < 2; s++)
			for (int a = 0; a < 2; a++)
			begin
				hit = (s == a);
				strap = 1'(s);
				m.start();
				xfer({oled_i2c_pkg::ADDR_FIXED, 1'(a), 1'b0}, hit);
				xfer(8'h40, hit);
				check(16'(addressed), 16'(hit));
				m.stop();
			end
		check(16'(mem_q.size() + cmd_q.size()), 16'h0000);
	endtask

	task automatic sc_cmd();
		clear();
		strap = 1'b0;
		m.start();
		xfer(8'h78, 1'b1);
		check(16'(addressed), 16'h0001);
		xfer(8'h00, 1'b1);
		xfer(8'h13, 1'b1);
		xfer(8'h05, 1'b1);
		m.stop();
		check(16'(addressed), 16'h0000);
		check(16'(cmd_q.size()), 16'h0002);
		check(16'(cmd_q[0]), 16'h0013);
		check(16'(cmd_q[1]), 16'h0005);
		check(16'(mem_q.size()), 16'h0000);
		check(16'(column), 16'h0035);
	endtask

	task automatic sc_data();
		clear();
		m.start();
		xfer(8'h78, 1'b1);
		xfer(8'h40, 1'b1);
		xfer(8'hAA, 1'b1);
		xfer(8'h55, 1'b1);
		m.start();
		xfer(8'h78, 1'b1);
		xfer(8'h80, 1'b1);
		xfer(8'h00, 1'b1);
		xfer(8'hC0, 1'b1);
		xfer(8'h11, 1'b1);
		m.stop();
		check(16'(mem_q.size()), 16'h0003);
		check(mem_q[0], 16'h35AA);
		check(mem_q[1], 16'h3655);
		check(mem_q[2], 16'h3011);
		check(16'(cmd_q.size()), 16'h0001);
		check(16'(column), 16'h0031);
	endtask

	task automatic sc_raw();
		clear();
		m.start();
		xfer(8'h78, 1'b1);
		xfer(8'h5A, 1'b1);
		m.stop();
		check(16'(mem_q.size()), 16'h0001);
		check(mem_q[0], 16'h315A);
		check(16'(column), 16'h0032);
	endtask

	task automatic sc_read();
		clear();
		m.start();
		xfer(8'h79, 1'b1);
		check(16'(addressed), 16'h0000);
		xfer(8'hFF, 1'b0);
		m.stop();
		check(16'(mem_q.size() + cmd_q.size()), 16'h0000);
	endtask

	initial
	begin
		rst_n = 1'b0;
		strap = 1'b0;
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		sc_reset();
		sc_addr();
		sc_cmd();
		sc_data();
		sc_raw();
		sc_read();
		end_sim();
	end

	initial
	begin
		#600000;
		n_errors++;
		end_sim();
	end
endmodule // oled_i2c_write_port_tb_top
